// [logic/phy_mii_register_view.sv]
// PHY management register view with aliased port control/status storage
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/100ps
module phy_mii_register_view
  import phy_view_pkg::*;
#(
  // Arbitrary neutral identifier value
  parameter logic [15:0] ID_UPPER = 16'h5A3C
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [4:0]  port1_partner_ability_in,
  output logic      [4:0]  port1_advertise,
  output logic             port2_far_loopback,
  output logic             port2_speed_100,
  output logic             port2_an_enable,
  output logic             port2_power_down,
  output logic             port2_an_restart,
  output logic             port2_full_duplex,
  output logic             crossover_algorithm_select,
  output logic             port2_force_mdix,
  output logic             port2_disable_auto_mdix,
  output logic             port2_tx_disable,
  output logic             port_led_disable
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  state_t      q;
  state_t      d;
  logic [5:0]  idx;
  logic [15:0] lane_mask;
  logic [15:0] view;
  logic [15:0] image;

  assign idx       = address[7:2];
  assign lane_mask = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Alias mapping between basic control layout and port 2 control bank

  function automatic logic [15:0] to_bank(input logic [15:0] ctrl);
    logic [15:0] bank;
    bank = 16'h0000;
    for (int i = 0; i < ALIAS_COUNT; i++) begin
      bank[ALIAS_BANK[i]] = ctrl[ALIAS_STD[i]];
    end
    return bank;
  endfunction

  function automatic logic [15:0] from_bank(input logic [15:0] bank,
                                            input logic [15:0] ctrl);
    logic [15:0] res;
    res = ctrl;
    for (int i = 0; i < ALIAS_COUNT; i++) begin
      res[ALIAS_STD[i]] = bank[ALIAS_BANK[i]];
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read views, all but the identifier (a parameter) built from the one set of storage bits

  always_comb begin
    if (idx == IDX_P2_BASIC_CTRL) begin
      view = q.ctrl & BC_WRITE_MASK;
    end else if (idx == IDX_P1_ID_UPPER) begin
      view = ID_UPPER;
    end else if (idx == IDX_P1_ADVERTISE) begin
      view = {5'h00, q.adv[4], q.adv_rsvd9, q.adv[3:0],
              ADV_SELECTOR};
    end else if (idx == IDX_P1_PARTNER) begin
      view = {5'h00, q.partner[4], 1'b0, q.partner[3:0],
              PARTNER_LOW};
    end else if (idx == IDX_P1_PORT_CTRL) begin
      view = {11'h000, q.adv};
    end else if (idx == IDX_P1_PORT_STATUS) begin
      view = {11'h000, q.partner};
    end else if (idx == IDX_P2_PORT_CTRL) begin
      view = to_bank(q.ctrl);
    end else if (idx == IDX_P2_PORT_STATUS) begin
      view = 16'h0000;
      view[P2_STATUS_XOVER] = q.ctrl[BC_XOVER_ALG];
    end else begin
      view = 16'h0000;
    end
  end

  // Byte lanes not enabled keep what the view already holds
  assign image = (view & ~lane_mask) | (writedata[15:0] & lane_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Next state: two-cycle handshake, write lands on the acknowledge edge

  always_comb begin
    d         = q;
    d.waitreq = 1'b1;
    d.restart = 1'b0;
    // Partner abilities follow the PHY every cycle
    d.partner = port1_partner_ability_in;
    if (q.waitreq) begin
      if (read || write) begin
        // Read data is captured a cycle early so it can come from a flop
        d.waitreq = 1'b0;
        d.rdata   = view;
      end
    end else if (write) begin
      if (idx == IDX_P2_BASIC_CTRL) begin
        d.ctrl    = image & BC_WRITE_MASK;
        d.restart = writedata[BC_AN_RESTART]
                    & lane_mask[BC_AN_RESTART];
      end else if (idx == IDX_P1_ADVERTISE) begin
        d.adv       = {image[10], image[8:5]};
        d.adv_rsvd9 = image[9];
      end else if (idx == IDX_P1_PORT_CTRL) begin
        d.adv = image[4:0];
      end else if (idx == IDX_P2_PORT_CTRL) begin
        d.ctrl    = from_bank(image, q.ctrl) & BC_WRITE_MASK;
        d.restart = writedata[P2_BANK_RESTART]
                    & lane_mask[P2_BANK_RESTART];
      end else if (idx == IDX_P2_PORT_STATUS) begin
        d.ctrl[BC_XOVER_ALG] = image[P2_STATUS_XOVER];
      end
      // Identifier, partner, port 1 status and unmapped words drop the write
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state

  assign readdata                   = {16'h0000, q.rdata};
  assign waitrequest                = q.waitreq;
  assign port1_advertise            = q.adv;
  assign port2_far_loopback         = q.ctrl[BC_LOOPBACK];
  assign port2_speed_100            = q.ctrl[BC_SPEED_100];
  assign port2_an_enable            = q.ctrl[BC_AN_ENABLE];
  assign port2_full_duplex          = q.ctrl[BC_FULL_DUPLEX];
  assign port2_power_down           = q.ctrl[BC_POWER_DOWN];
  assign port2_an_restart           = q.restart;
  assign crossover_algorithm_select = q.ctrl[BC_XOVER_ALG];
  assign port2_force_mdix           = q.ctrl[BC_FORCE_MDIX];
  assign port2_disable_auto_mdix    = q.ctrl[BC_DISABLE_MDIX];
  assign port2_tx_disable           = q.ctrl[BC_TX_DISABLE];
  assign port_led_disable           = q.ctrl[BC_LED_DISABLE];

endmodule

// [logic/phy_view_pkg.sv]
// Constants, field layouts and state type of the PHY register view
package phy_view_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [5:0] IDX_P2_BASIC_CTRL   = 6'h00;
  localparam logic [5:0] IDX_P1_ID_UPPER     = 6'h06;
  localparam logic [5:0] IDX_P1_ADVERTISE    = 6'h08;
  localparam logic [5:0] IDX_P1_PARTNER      = 6'h0A;
  localparam logic [5:0] IDX_P1_PORT_CTRL    = 6'h10;
  localparam logic [5:0] IDX_P1_PORT_STATUS  = 6'h12;
  localparam logic [5:0] IDX_P2_PORT_CTRL    = 6'h14;
  localparam logic [5:0] IDX_P2_PORT_STATUS  = 6'h16;

  // Low fields fixed by the standard view
  localparam logic [4:0]  ADV_SELECTOR       = 5'h01;
  localparam logic [4:0]  PARTNER_LOW        = 5'h01;

  // Basic control field positions (standard view)
  localparam int unsigned BC_LOOPBACK        = 14;
  localparam int unsigned BC_SPEED_100       = 13;
  localparam int unsigned BC_AN_ENABLE       = 12;
  localparam int unsigned BC_POWER_DOWN      = 11;
  localparam int unsigned BC_AN_RESTART      = 9;
  localparam int unsigned BC_FULL_DUPLEX     = 8;
  localparam int unsigned BC_XOVER_ALG       = 5;
  localparam int unsigned BC_FORCE_MDIX      = 4;
  localparam int unsigned BC_DISABLE_MDIX    = 3;
  localparam int unsigned BC_TX_DISABLE      = 1;
  localparam int unsigned BC_LED_DISABLE     = 0;

  // Writable bits of the basic control view and their reset value
  localparam logic [15:0] BC_WRITE_MASK      = 16'h7B3F;
  localparam logic [15:0] BC_RESET           = 16'h1020;

  // Alias map: standard-view bit and port 2 control bank bit, pairwise
  localparam int unsigned ALIAS_COUNT        = 11;
  localparam int unsigned ALIAS_STD [ALIAS_COUNT] =
    '{14, 13, 12, 11, 9, 8, 4, 3, 2, 1, 0};
  localparam int unsigned ALIAS_BANK [ALIAS_COUNT] =
    '{8, 6, 7, 11, 13, 5, 9, 10, 12, 14, 15};
  // Crossover algorithm bit position in the port 2 status bank
  localparam int unsigned P2_STATUS_XOVER    = 15;
  localparam int unsigned P2_BANK_RESTART    = 13;

  // Advertisement storage {pause, 100F, 100H, 10F, 10H}, all set at reset
  localparam logic [4:0]  ADV_RESET          = 5'h1F;
  localparam logic [4:0]  PARTNER_RESET      = 5'h00;
  localparam logic [15:0] RDATA_RESET        = 16'h0000;

  typedef struct packed {
    logic        waitreq;
    logic [15:0] rdata;
    logic [4:0]  adv;
    logic        adv_rsvd9;
    logic [4:0]  partner;
    logic [15:0] ctrl;
    logic        restart;
  } state_t;

  localparam state_t STATE_RESET = '{
    waitreq:   1'b1,
    rdata:     RDATA_RESET,
    adv:       ADV_RESET,
    adv_rsvd9: 1'b0,
    partner:   PARTNER_RESET,
    ctrl:      BC_RESET,
    restart:   1'b0
  };

endpackage

// [verif/phy_view_properties.sv]
// Concurrent checks of the PHY register view
`timescale 1ns/100ps
module phy_view_properties
  import phy_view_pkg::*;
#(
  parameter logic [15:0] ID_UPPER = 16'h5A3C
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [4:0]  port1_partner_ability_in,
  input wire logic [4:0]  port1_advertise,
  input wire logic        port2_far_loopback,
  input wire logic        port2_an_enable,
  input wire logic        port2_an_restart,
  input wire logic        crossover_algorithm_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic       rq;
  logic       wq;
  logic [5:0] idx;
  assign idx = address[7:2];
  assign rq  = read && waitrequest;
  // Only the upper lane carries loopback and restart
  assign wq  = write && waitrequest && idx == 6'h00 && byteenable[1];
  AST_ID_UPPER: assert property (rq && idx == 6'h06 |=>
    readdata == {16'h0000, ID_UPPER}) else $error("id read wrong");
  AST_ADV_FIXED: assert property (rq && idx == 6'h08 |=>
    readdata[4:0] == 5'h01 && readdata[15:11] == 5'h00)
    else $error("advert fixed bits wrong");
  AST_ADV_VIEW: assert property (rq && idx == 6'h08 |=>
    {readdata[10], readdata[8:5]} == $past(port1_advertise))
    else $error("advert view differs from storage");
  AST_LP_FIXED: assert property (rq && idx == 6'h0A |=>
    readdata[4:0] == 5'h01 && readdata[15:11] == 5'h00 && !readdata[9])
    else $error("partner fixed bits wrong");
  AST_LP_MIRROR: assert property (rq && idx == 6'h0A |=>
    {readdata[10], readdata[8:5]} == $past(port1_partner_ability_in, 2))
    else $error("partner view differs from input");
  AST_CTRL_VIEW: assert property (rq && idx == 6'h00 |=>
    readdata[15] == 1'b0 && readdata[10] == 1'b0 && readdata[7:6] == 2'b00
    && readdata[12] == $past(port2_an_enable)
    && readdata[5] == $past(crossover_algorithm_select))
    else $error("control view wrong");
  AST_RESTART: assert property (wq && writedata[9] |->
    ##2 port2_an_restart ##1 !port2_an_restart)
    else $error("restart pulse wrong");
  AST_LOOPBACK: assert property (wq |->
    ##2 port2_far_loopback == $past(writedata[14], 2))
    else $error("loopback output wrong");
endmodule

// [verif/tb.sv]
// Register-level testbench of the PHY register view
`timescale 1ns/100ps
module tb;
  import phy_view_pkg::*;
  logic        clk;
  logic        reset;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [4:0]  pai;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [4:0]  adv;
  logic [9:0]  ctl;
  logic [31:0] rd_q;
  int          n_errors;
  int          n_compared;
  phy_mii_register_view i_dut (
    .clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .port1_partner_ability_in(pai), .port1_advertise(adv),
    .port2_far_loopback(ctl[9]), .port2_speed_100(ctl[8]),
    .port2_an_enable(ctl[7]), .port2_power_down(ctl[6]),
    .port2_an_restart(), .port2_full_duplex(ctl[5]),
    .crossover_algorithm_select(ctl[4]), .port2_force_mdix(ctl[3]),
    .port2_disable_auto_mdix(ctl[2]), .port2_tx_disable(ctl[1]),
    .port_led_disable(ctl[0]));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic end_of_test();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Idle edge first so a release is never overwritten in one time step
  task automatic acc(logic w, logic [5:0] i, logic [15:0] d, logic [1:0] b);
    int n;
    n = 0;
    @(posedge clk);
    address    <= {i, 2'b00};
    read       <= !w;
    write      <= w;
    writedata  <= {16'h0000, d};
    byteenable <= {2'b00, b};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      n_errors++;
      end_of_test();
    end
    @(posedge clk);
    rd_q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic rd(string nm, logic [5:0] i, logic [15:0] e);
    acc(1'b0, i, 16'h0000, 2'b00);
    chk(nm, {16'h0000, e}, rd_q);
  endtask
  task automatic wr(logic [5:0] i, logic [15:0] d, logic [1:0] b);
    acc(1'b1, i, d, b);
  endtask
  initial begin
    n_errors = 0;
    n_compared = 0;
    reset = 1'b1;
    {address, read, write, writedata, byteenable, pai} = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd("bctl_rst", IDX_P2_BASIC_CTRL, 16'h1020);
    chk("ctl_rst", 32'h0000_0090, {22'h0, ctl});
    rd("id_upper", IDX_P1_ID_UPPER, 16'h5A3C);
    rd("adv_rst", IDX_P1_ADVERTISE, 16'h05E1);
    rd("lp_rst", IDX_P1_PARTNER, 16'h0001);
    wr(IDX_P1_ID_UPPER, 16'hFFFF, 2'b11);
    rd("id_ro", IDX_P1_ID_UPPER, 16'h5A3C);
    wr(IDX_P2_BASIC_CTRL, 16'hFFFF, 2'b11);
    rd("bctl_all", IDX_P2_BASIC_CTRL, 16'h7B3F);
    chk("ctl_all", 32'h0000_03FF, {22'h0, ctl});
    wr(IDX_P2_BASIC_CTRL, 16'h0000, 2'b01);
    rd("bctl_lane", IDX_P2_BASIC_CTRL, 16'h7B00);
    wr(IDX_P2_PORT_STATUS, 16'h8000, 2'b11);
    rd("xover", IDX_P2_BASIC_CTRL, 16'h7B20);
    wr(IDX_P2_PORT_CTRL, 16'h0000, 2'b11);
    rd("bank_alias", IDX_P2_BASIC_CTRL, 16'h0020);
    wr(IDX_P1_PORT_CTRL, 16'h0005, 2'b01);
    rd("adv_alias", IDX_P1_ADVERTISE, 16'h00A1);
    chk("adv_out", 32'h0000_0005, {27'h0, adv});
    wr(IDX_P1_ADVERTISE, 16'hFFFF, 2'b11);
    rd("adv_bank", IDX_P1_PORT_CTRL, 16'h001F);
    rd("adv_all", IDX_P1_ADVERTISE, 16'h07E1);
    pai <= 5'h15;
    wr(IDX_P1_PARTNER, 16'hFFFF, 2'b11);
    rd("lp", IDX_P1_PARTNER, 16'h04A1);
    rd("unmapped", 6'h3F, 16'h0000);
    end_of_test();
  end
endmodule
bind phy_mii_register_view phy_view_properties #(.ID_UPPER(ID_UPPER)) i_prop (
  .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
  .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
  .waitrequest(waitrequest),
  .port1_partner_ability_in(port1_partner_ability_in),
  .port1_advertise(port1_advertise), .port2_far_loopback(port2_far_loopback),
  .port2_an_enable(port2_an_enable), .port2_an_restart(port2_an_restart),
  .crossover_algorithm_select(crossover_algorithm_select));
